/* fxt_trigger_unit.v */
// Exception trigger and bounce unit of the floating-point coprocessor
`timescale 1ns/100ps
`default_nettype none
`include "fxt_defines.vh"

// Functional notes
// - Exceptions are reported only by bouncing a later instruction.
// - Data op right after last vector iteration enters the pretrigger slot.
// - Captured pretrigger word gets always-condition and sets bit 28.
// - Bit 28 clears when no pretrigger instruction was captured.
// - First nonserializing instruction after detection is the trigger.
// - Status/control register access is always a trigger.
// - Privileged exception, faulting, pretrigger reg access never triggers.
// - Identification register access never triggers.
// - Instructions already past issue are never the trigger.
// - Scalar exception loads faulting register and records condition.
// - Exceptional instruction is killed; busy pipes drain normally.
// - Instruction waiting in issue bounces the cycle after detection.
// - Without one, bounce the next issued instruction.
// - Iterations issued before the exceptional one retire normally.
// - Exceptional vector iteration sets pending flag bit 31.
// - Register fields are rewritten to the iteration's registers.
// - Bits 10:8 hold remaining iterations minus one.
// - Matching type flag set; pending reads 1 while exceptional.
// - Double multiply spends two cycles in second execute stage.
// - Vector length is size field plus one; stride one.
// - Bits 10:8 read 111 when no iterations remain.
// - Undefined bounce without pending exception leaves bit 31 clear.

module fxt_trigger_unit (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // Issue stage
  input wire iss_valid,
  input wire iss_is_sysreg,
  input wire [2:0] iss_sysreg_sel,
  input wire iss_privileged,
  input wire iss_undefined,
  output wire iss_hold,
  output wire bounce_undef,
  // Second execute stage of the multiply-add pipe
  input wire e2_valid,
  input wire e2_dp_mul,
  output wire e2_stall,
  // Potential exception from the data pipes
  input wire det_valid,
  input wire [31:0] det_word,
  input wire det_is_vector,
  input wire det_double,
  input wire [2:0] det_iter,
  input wire [2:0] det_len,
  input wire [3:0] det_type,
  output wire exc_kill,
  // Pretrigger slot
  input wire pre_valid,
  input wire [31:0] pre_word,
  // State seen by the core
  output wire exc_pending
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg pend_q;
  reg en_q;
  reg second_q;
  reg [2:0] iter_q;
  reg [3:0] type_q;
  reg [31:0] fault_q;
  reg [31:0] pretrig_q;
  reg bounce_q;
  reg e2_first_q;

  // ----------------------------------------------------------------
  // Double multiply occupancy of the second execute stage
  // ----------------------------------------------------------------
  // First cycle of a double multiply holds the stage; results and any
  // exception appear only on the second cycle.
  wire e2_dp = e2_valid & e2_dp_mul;
  wire e2_done = ~e2_dp | e2_first_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      e2_first_q <= 1'b0;
    end else begin
      e2_first_q <= e2_dp & ~e2_first_q;
    end
  end

  assign e2_stall = e2_dp & ~e2_first_q;

  // ----------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------
  // A second detection while one is already pending is dropped: the
  // pipe is draining and the first record must survive for software.
  wire det_take = det_valid & e2_done & ~pend_q;

  // Kill the exceptional iteration and all later ones; earlier
  // iterations and other pipe contents keep running to completion.
  assign exc_kill = det_take;

  // ----------------------------------------------------------------
  // Register field rewrite for a vector iteration
  // ----------------------------------------------------------------
  // Bank 0 operands are scalar and keep their address.
  function [4:0] fxt_step_single;
    input [4:0] s;
    input [2:0] it;
    begin
      if (s[4:3] == 2'h0) begin
        fxt_step_single = s;
      end else begin
        fxt_step_single = {s[4:3], s[2:0] + it};
      end
    end
  endfunction

  function [3:0] fxt_step_double;
    input [3:0] d;
    input [2:0] it;
    begin
      if (d[3:2] == 2'h0) begin
        fxt_step_double = d;
      end else begin
        fxt_step_double = {d[3:2], d[1:0] + it[1:0]};
      end
    end
  endfunction

  reg [31:0] rew_word;
  reg [4:0] sd;
  reg [4:0] sn;
  reg [4:0] sm;

  always @* begin
    rew_word = det_word;
    sd = fxt_step_single({det_word[15:12], det_word[22]}, det_iter);
    sn = fxt_step_single({det_word[19:16], det_word[7]}, det_iter);
    sm = fxt_step_single({det_word[3:0], det_word[5]}, det_iter);
    if (det_is_vector) begin
      if (det_double) begin
        rew_word[15:12] = fxt_step_double(det_word[15:12], det_iter);
        rew_word[19:16] = fxt_step_double(det_word[19:16], det_iter);
        rew_word[3:0] = fxt_step_double(det_word[3:0], det_iter);
      end else begin
        rew_word[15:12] = sd[4:1];
        rew_word[22] = sd[0];
        rew_word[19:16] = sn[4:1];
        rew_word[7] = sn[0];
        rew_word[3:0] = sm[4:1];
        rew_word[5] = sm[0];
      end
    end
  end

  // Length is field+1 and stride one, so remaining-1 is len-iter-1;
  // the 3-bit wrap yields 111 on the last iteration.
  wire [2:0] iter_left = det_is_vector ?
    (det_len - det_iter - 3'h1) : 3'h7;

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  wire sys_quiet = iss_is_sysreg &
    ((iss_sysreg_sel == `FXT_SYS_IDENT) |
     (iss_privileged & ((iss_sysreg_sel == `FXT_SYS_EXC) |
                        (iss_sysreg_sel == `FXT_SYS_FAULT) |
                        (iss_sysreg_sel == `FXT_SYS_PRETRIG))));
  // Status/control access falls through as a trigger in any mode.
  wire cand = iss_valid & ~sys_quiet;

  // Only the issue stage is examined, so anything already executing
  // can never become the trigger.
  wire exc_armed = pend_q | det_take;
  wire undef_hit = iss_valid & ~sys_quiet & (iss_undefined | ~en_q);
  wire trig_now = ~bounce_q & ((exc_armed & cand) | undef_hit);

  // Issue stage is frozen while the bounce is being decided, so an
  // instruction present at detection is the one bounced next cycle.
  // Undefined bounces freeze the issue stage as well, so the core
  // always sees the response against the instruction it still holds.
  assign iss_hold = trig_now;

  always @(posedge aclk) begin
    if (!aresetn) begin
      bounce_q <= 1'b0;
    end else begin
      bounce_q <= trig_now;
    end
  end

  assign bounce_undef = bounce_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  reg aw_q;
  reg [11:0] awaddr_q;
  reg w_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;

  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready = ~w_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  wire wr_fire = aw_q & w_q & ~bvalid_q;
  wire wr_stat = wr_fire & ({awaddr_q[11:2], 2'h0} == `FXT_OFF_STATUS);
  wire wr_fault = wr_fire & ({awaddr_q[11:2], 2'h0} == `FXT_OFF_FAULT);
  wire wr_pre = wr_fire & ({awaddr_q[11:2], 2'h0} == `FXT_OFF_PRETRIG);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      awaddr_q <= 12'h000;
      w_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `FXT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_stat | wr_fault | wr_pre) ?
          `FXT_RESP_OKAY : `FXT_RESP_SLVERR;
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Byte-lane merge of a write into a 32-bit register
  function [31:0] fxt_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      fxt_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          fxt_merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] status_rd;
  assign status_rd = {pend_q, en_q, 1'b0, second_q, 17'h00000, iter_q,
    type_q[`FXT_TYPE_INSUB], 3'h0, type_q[`FXT_TYPE_UNDER],
    type_q[`FXT_TYPE_OVER], 1'b0, type_q[`FXT_TYPE_INVOP]};
  wire [31:0] status_wr = fxt_merge(status_rd, wdata_q, wstrb_q);
  wire [31:0] status_rst = `FXT_STATUS_RST;

  // ----------------------------------------------------------------
  // Exception status, faulting and pretrigger registers
  // ----------------------------------------------------------------
  // Hardware detection wins over a software write in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= status_rst[`FXT_BIT_PENDING];
      en_q <= status_rst[`FXT_BIT_ENABLE];
      second_q <= 1'b0;
      iter_q <= 3'h0;
      type_q <= 4'h0;
      fault_q <= 32'h00000000;
      pretrig_q <= 32'h00000000;
    end else if (det_take) begin
      pend_q <= 1'b1;
      iter_q <= iter_left;
      type_q <= det_type;
      fault_q <= rew_word;
      second_q <= pre_valid;
      if (pre_valid) begin
        pretrig_q <= {`FXT_COND_ALWAYS, pre_word[27:0]};
      end
    end else begin
      if (wr_stat) begin
        pend_q <= status_wr[`FXT_BIT_PENDING];
        en_q <= status_wr[`FXT_BIT_ENABLE];
        second_q <= status_wr[`FXT_BIT_SECOND];
        iter_q <= status_wr[`FXT_ITER_HI:`FXT_ITER_LO];
        type_q[`FXT_TYPE_INSUB] <= status_wr[`FXT_BIT_INSUB];
        type_q[`FXT_TYPE_UNDER] <= status_wr[`FXT_BIT_UNDER];
        type_q[`FXT_TYPE_OVER] <= status_wr[`FXT_BIT_OVER];
        type_q[`FXT_TYPE_INVOP] <= status_wr[`FXT_BIT_INVOP];
      end
      if (wr_fault) begin
        fault_q <= fxt_merge(fault_q, wdata_q, wstrb_q);
      end
      if (wr_pre) begin
        pretrig_q <= fxt_merge(pretrig_q, wdata_q, wstrb_q);
      end
    end
  end

  assign exc_pending = pend_q;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `FXT_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `FXT_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'h0})
        `FXT_OFF_STATUS: rdata_q <= status_rd;
        `FXT_OFF_FAULT: rdata_q <= fault_q;
        `FXT_OFF_PRETRIG: rdata_q <= pretrig_q;
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= `FXT_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // fxt_trigger_unit
`default_nettype wire

/* fxt_defines.vh */
// Register map, field positions, reset values and codes of the trigger unit
`ifndef FXT_DEFINES_VH
`define FXT_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FXT_OFF_STATUS 12'h000
`define FXT_OFF_FAULT 12'h004
`define FXT_OFF_PRETRIG 12'h008

// ----------------------------------------------------------------
// Exception status register fields
// ----------------------------------------------------------------
`define FXT_BIT_PENDING 31
`define FXT_BIT_ENABLE 30
`define FXT_BIT_SECOND 28
`define FXT_ITER_HI 10
`define FXT_ITER_LO 8
`define FXT_BIT_INSUB 7
`define FXT_BIT_UNDER 3
`define FXT_BIT_OVER 2
`define FXT_BIT_INVOP 0
`define FXT_STATUS_RST 32'h40000000

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define FXT_COND_HI 31
`define FXT_COND_LO 28
`define FXT_COND_ALWAYS 4'hE

// ----------------------------------------------------------------
// Exception type inputs, one bit each
// ----------------------------------------------------------------
`define FXT_TYPE_INVOP 0
`define FXT_TYPE_OVER 1
`define FXT_TYPE_UNDER 2
`define FXT_TYPE_INSUB 3

// ----------------------------------------------------------------
// System register selectors of a register-access instruction
// ----------------------------------------------------------------
`define FXT_SYS_IDENT 3'h0
`define FXT_SYS_STATCTL 3'h1
`define FXT_SYS_EXC 3'h2
`define FXT_SYS_FAULT 3'h3
`define FXT_SYS_PRETRIG 3'h4

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define FXT_RESP_OKAY 2'h0
`define FXT_RESP_SLVERR 2'h2

`endif

/* fxt_trigger_unit_chk.sv */
// Concurrent property checker bound to the trigger unit ports
`timescale 1ns/100ps
`default_nettype none
module fxt_trigger_unit_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Issue stage
  input wire logic iss_valid,
  input wire logic iss_is_sysreg,
  input wire logic [2:0] iss_sysreg_sel,
  input wire logic iss_privileged,
  input wire logic iss_undefined,
  input wire logic iss_hold,
  input wire logic bounce_undef,
  // Pipes and detection
  input wire logic e2_valid,
  input wire logic e2_dp_mul,
  input wire logic e2_stall,
  input wire logic exc_kill,
  input wire logic exc_pending
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_kill_bounce: assert property (
    exc_kill && iss_valid && !iss_is_sysreg && !bounce_undef |=> bounce_undef)
    else $error("no bounce after detection in issue");
  a_kill_pend: assert property (exc_kill |=> exc_pending)
    else $error("pending flag not set after detection");
  a_pend_trig: assert property (
    iss_valid && exc_pending && !iss_is_sysreg && !bounce_undef
    |=> bounce_undef) else $error("pending trigger not bounced");
  a_statctl_trig: assert property (
    iss_valid && iss_is_sysreg && iss_sysreg_sel == 3'h1 && exc_pending &&
    !bounce_undef |=> bounce_undef) else $error("status access not bounced");
  a_ident_quiet: assert property (
    iss_valid && iss_is_sysreg && iss_sysreg_sel == 3'h0 |=> !bounce_undef)
    else $error("ident access bounced");
  a_priv_quiet: assert property (
    iss_valid && iss_is_sysreg && iss_privileged &&
    iss_sysreg_sel inside {3'h2, 3'h3, 3'h4} |=> !bounce_undef)
    else $error("privileged access bounced");
  a_bounce_pulse: assert property (bounce_undef |=> !bounce_undef)
    else $error("bounce longer than one cycle");
  a_hold_trig: assert property (
    $rose(bounce_undef) |-> $past(iss_hold))
    else $error("bounce without hold in trigger cycle");
  a_stall_first: assert property (
    $rose(e2_valid && e2_dp_mul) |-> e2_stall ##1 !e2_stall)
    else $error("double multiply stall not one extra cycle");
  a_kill_quiet: assert property (
    exc_pending || e2_stall |-> !exc_kill)
    else $error("detection accepted while pending or stalled");
  a_undef_clear: assert property (
    iss_valid && iss_undefined && !iss_is_sysreg && !exc_pending &&
    !exc_kill && !bounce_undef |=> bounce_undef && !exc_pending)
    else $error("undefined bounce wrong");
endmodule // fxt_trigger_unit_chk
bind fxt_trigger_unit fxt_trigger_unit_chk chk (.*);
`default_nettype wire

/* fxt_core_model.sv */
// Processor core model issuing coprocessor instructions
`timescale 1ns/100ps
`default_nettype none
module fxt_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Coprocessor answers
  input wire logic iss_hold,
  input wire logic bounce_undef,
  // Issue request
  output logic iss_valid,
  output logic iss_is_sysreg,
  output logic [2:0] iss_sysreg_sel,
  output logic iss_privileged,
  output logic iss_undefined
);
  int n_undef;
  logic stuck;
  logic [5:0] last;
  initial begin
    {iss_valid, iss_is_sysreg, iss_sysreg_sel} = 5'h00;
    {iss_privileged, iss_undefined} = 2'h0;
    n_undef = 0;
    stuck = 1'h0;
  end
  // Undefined-instruction exception taken per bounce
  always @(posedge aclk) begin
    if (aresetn && bounce_undef) begin
      n_undef <= n_undef + 1;
    end
  end
  task issue(input logic s, input logic [2:0] sel, input logic p, u,
             output logic b);
    int i;
    b = 1'h0;
    last = {s, sel, p, u};
    @(posedge aclk);
    iss_valid <= 1'h1;
    {iss_is_sysreg, iss_sysreg_sel, iss_privileged, iss_undefined} <= last;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      b = b | bounce_undef;
      if (!iss_hold || bounce_undef) break;
    end
    if (i == 20) stuck = 1'h1;
    iss_valid <= 1'h0;
    // Idle fields scrambled so nothing relies on stale values
    {iss_is_sysreg, iss_sysreg_sel, iss_privileged, iss_undefined} <= ~last;
  endtask
  task retry(output logic b);
    issue(last[5], last[4:2], last[1], last[0], b);
  endtask
endmodule // fxt_core_model
`default_nettype wire

/* fxt_trigger_unit_test.sv */
// Self-checking testbench of the trigger unit
`timescale 1ns/100ps
`default_nettype none
module fxt_trigger_unit_test;
  logic aclk, aresetn, b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, iss_valid;
  logic iss_is_sysreg, iss_privileged, iss_undefined, iss_hold;
  logic bounce_undef, e2_valid, e2_dp_mul, e2_stall, det_valid;
  logic det_is_vector, det_double, exc_kill, pre_valid, exc_pending;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] s_axi_awprot, s_axi_arprot, iss_sysreg_sel, det_iter, det_len;
  logic [3:0] s_axi_wstrb, det_type;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, det_word, pre_word, d;
  int n_fail, cmp_count;
  // Rows: is_sysreg, selector, privileged, bounce expected
  logic [5:0] rows [9] = '{6'h01, 6'h25, 6'h27, 6'h20, 6'h22, 6'h2A,
                          6'h2E, 6'h32, 6'h2D};
  fxt_trigger_unit uut (.*);
  fxt_core_model core (.*);
  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task stop_test;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    int i;
    logic dn;
    dn = 1'h0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (i = 0; i < 50 && !dn; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        dn = 1'h1;
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
      end
    end
    if (!dn) begin
      n_fail++;
      stop_test();
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    int i;
    logic dn;
    dn = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (i = 0; i < 50 && !dn; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        dn = 1'h1;
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
      end
    end
    if (!dn) begin
      n_fail++;
      stop_test();
    end
    chk(d, exp);
  endtask
  // Detection with the trigger issued dl cycles after the detect pulse
  task detect(input logic v, input logic [2:0] ln, it,
              input logic [3:0] ty, input logic pv, input int dl);
    wr(12'h000, 32'h40000000);
    {det_is_vector, det_len, det_iter, det_type, pre_valid} <=
      {v, ln, it, ty, pv};
    fork
      begin
        repeat (dl) @(posedge aclk);
        core.issue(1'h0, 3'h0, 1'h0, 1'h0, b);
      end
      begin
        @(posedge aclk);
        det_valid <= 1'h1;
        @(posedge aclk);
        det_valid <= 1'h0;
      end
    join
    chk({31'h0, b}, 32'h1);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {n_fail, cmp_count} = 64'h0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
    {s_axi_rready, e2_valid, e2_dp_mul, det_valid, det_is_vector} = 5'h0;
    {det_double, pre_valid, det_iter, det_len, det_type} = 12'h000;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {det_word, pre_word} = {32'h0E012A03, 32'h0E345678};
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(12'h000, 32'h40000000);
    rd(12'h00C, 32'h0);
    chk({30'h0, r}, 32'h2);
    wr(12'h00C, 32'hFFFFFFFF);
    chk({30'h0, r}, 32'h2);
    detect(1'h0, 3'h0, 3'h0, 4'h2, 1'h0, 0);
    rd(12'h000, 32'hC0000704);
    rd(12'h004, 32'h0E012A03);
    foreach (rows[i]) begin
      core.issue(rows[i][5], rows[i][4:2], rows[i][1], 1'h0, b);
      chk({31'h0, b}, {31'h0, rows[i][0]});
    end
    wr(12'h000, 32'h40000000);
    chk({30'h0, r}, 32'h0);
    core.retry(b);
    chk({31'h0, b}, 32'h0);
    detect(1'h1, 3'h1, 3'h0, 4'h4, 1'h1, 3);
    rd(12'h000, 32'hD0000008);
    rd(12'h008, 32'hEE345678);
    rd(12'h004, 32'h0E012A03);
    // Banked operands S24, S26, S28 step to S25, S27, S29
    det_word <= 32'h0E0DCA0E;
    detect(1'h1, 3'h3, 3'h1, 4'h1, 1'h0, 2);
    rd(12'h000, 32'hC0000101);
    rd(12'h004, 32'h0E4DCAAE);
    detect(1'h1, 3'h3, 3'h3, 4'h8, 1'h0, 1);
    rd(12'h000, 32'hC0000780);
    // Reset in mid-run with an exception pending
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(12'h000, 32'h40000000);
    rd(12'h004, 32'h0);
    chk({31'h0, exc_pending}, 32'h0);
    wr(12'h000, 32'h40000000);
    core.issue(1'h0, 3'h0, 1'h0, 1'h1, b);
    chk({31'h0, b}, 32'h1);
    rd(12'h000, 32'h40000000);
    // Detection during the double-multiply stall cycle is dropped
    @(posedge aclk);
    {e2_valid, e2_dp_mul, det_valid} <= 3'h7;
    @(posedge aclk);
    det_valid <= 1'h0;
    @(posedge aclk);
    {e2_valid, e2_dp_mul} <= 2'h0;
    rd(12'h000, 32'h40000000);
    chk(core.n_undef, 32'h9);
    chk({31'h0, core.stuck}, 32'h0);
    stop_test();
  end
endmodule // fxt_trigger_unit_test
`default_nettype wire
